// *** rtl/ccs_pkg.sv ***
// package of offsets, field layouts, reset values and carriers for the can control/status block
package ccs_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFS_MODE_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MODE_STAT  = 8'h04;
    localparam logic [7:0] OFS_ERR_STAT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;

    // mode control field positions
    localparam int REQ_MSB   = 7;
    localparam int REQ_LSB   = 5;
    localparam int ABORT_BIT = 4;
    localparam int WIN_MSB   = 3;
    localparam int WIN_LSB   = 1;

    // mode status field positions
    localparam int MODE_MSB  = 7;
    localparam int MODE_LSB  = 5;
    localparam int CODE_MSB  = 3;
    localparam int CODE_LSB  = 1;

    // reset values
    localparam logic [7:0] RST_MODE_CTRL = 8'h80;
    localparam logic [2:0] RST_MODE      = 3'h4;
    localparam logic [5:0] RST_IRQ_MASK  = 6'h00;

    // operating mode codes
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_DISABLE  = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN   = 3'h3;
    localparam logic [2:0] MODE_CONFIG   = 3'h4;

    // buffer and interrupt source codes, shared by window select and interrupt code
    localparam logic [2:0] CODE_NONE  = 3'h0;
    localparam logic [2:0] CODE_ERROR = 3'h1;
    localparam logic [2:0] CODE_TRANSMIT_BUFFER_TWO  = 3'h2;
    localparam logic [2:0] CODE_TRANSMIT_BUFFER_ONE  = 3'h3;
    localparam logic [2:0] CODE_TRANSMIT_BUFFER_ZERO  = 3'h4;
    localparam logic [2:0] CODE_RECEIVE_BUFFER_ONE  = 3'h5;
    localparam logic [2:0] CODE_RECEIVE_BUFFER_ZERO  = 3'h6;
    localparam logic [2:0] CODE_WAKE  = 3'h7;

    // error counter thresholds
    localparam int LIM_WARN    = 95;
    localparam int LIM_PASSIVE = 127;
    localparam int LIM_BUSOFF  = 255;

    // wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ccs_wb_req_t;

    // pending interrupt sources from the buffers and protocol engine
    typedef struct packed {
        logic wake;
        logic receive_buffer_zero;
        logic receive_buffer_one;
        logic transmit_buffer_zero;
        logic transmit_buffer_one;
        logic transmit_buffer_two;
        logic error;
    } ccs_irq_src_t;

    // error state status register layout
    typedef struct packed {
        logic rx0_ovfl;
        logic rx1_ovfl;
        logic tx_busoff;
        logic tx_passive;
        logic rx_passive;
        logic tx_warn;
        logic rx_warn;
        logic any_warn;
    } ccs_err_t;

endpackage : ccs_pkg

// *** rtl/ccs_control_status.sv ***
// can controller mode control, interrupt code and error state status with wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// Functional notes
// - mode request 1xx configuration, 011 listen, 010 loopback, 001 disable, 000 normal.
// - abort-all bit set aborts all three transmit buffers; clear lets them proceed.
// - window 101 rx1, 100 tx0, 011 tx1, 010 tx2, any other rx0.
// - the chosen buffer is mapped into the common access area.
// - mode status reports mode in force; codes 101 to 111 never shown.
// - interrupt code 111 wake, 110 rx0, 101 rx1, 100..010 tx0..tx2, 001 error.
// - interrupt code and window select share one buffer encoding.
// - receive buffer 0 overflow flag set on overflow, held until software clears.
// - receive buffer 1 overflow flag set on overflow, held until software clears.
// - transmit bus-off flag is one while transmit count exceeds 255.
// - transmit error-passive flag is one while transmit count exceeds 127.
// - receive error-passive flag is one while receive count exceeds 127.
// - transmit warning is one when count is above 95 and at most 127.
// - receive warning is one when count is above 95 and at most 127.
// - combined warning is the or of the transmit and receive warnings.
// - control bit 0 and status bits 4 and 0 always read zero.
module ccs_control_status #(
    parameter int CNT_W = 9
) (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET_N,
    // wishbone slave
    input  wire ccs_pkg::ccs_wb_req_t  WB_REQ,
    output logic [31:0]                WB_DAT_O,
    output logic                       WB_ACK_O,
    // protocol engine mode handshake
    output logic [2:0]                 MODE_REQ,
    input  wire logic [2:0]            ENGINE_MODE,
    output logic                       ABORT_ALL,
    // buffer window
    output logic [4:0]                 WIN_BUF_EN,
    // interrupt sources and code
    input  wire ccs_pkg::ccs_irq_src_t IRQ_SRC,
    output logic [2:0]                 IRQ_CODE,
    // error counters and overflow events
    input  wire logic [CNT_W-1:0]      TX_ERR_CNT,
    input  wire logic [CNT_W-1:0]      RX_ERR_CNT,
    input  wire logic                  RX0_OVF_EV,
    input  wire logic                  RX1_OVF_EV,
    // interrupt output
    output logic                       IRQ
);

    // normalises a mode request, any top-bit value meaning configuration
    function automatic logic [2:0] mode_decode(input logic [2:0] req);
        mode_decode = req[2] ? ccs_pkg::MODE_CONFIG : req;
    endfunction : mode_decode

    // one-hot buffer enable from a buffer code: rx0, rx1, tx0, tx1, tx2
    function automatic logic [4:0] win_decode(input logic [2:0] code);
        unique case (code)
            ccs_pkg::CODE_RECEIVE_BUFFER_ONE: win_decode = 5'h02;
            ccs_pkg::CODE_TRANSMIT_BUFFER_ZERO: win_decode = 5'h04;
            ccs_pkg::CODE_TRANSMIT_BUFFER_ONE: win_decode = 5'h08;
            ccs_pkg::CODE_TRANSMIT_BUFFER_TWO: win_decode = 5'h10;
            default:            win_decode = 5'h01;
        endcase
    endfunction : win_decode

    logic [7:0]        ctrl_q;
    logic [2:0]        mode_q;
    logic [2:0]        code_q;
    logic [1:0]        ovfl_q;
    ccs_pkg::ccs_err_t err_d;
    ccs_pkg::ccs_err_t err_q;
    logic [5:0]        irq_stat_q;
    logic [5:0]        irq_mask_q;
    logic [5:0]        irq_ev;
    logic              ack_q;
    logic              wb_fire;
    logic              wr_fire;
    logic              rd_fire;
    logic [2:0]        code_d;
    logic              mode_ok;

    // bus handshake: answer one cycle after the request, act on the ack edge
    assign wb_fire = WB_REQ.cyc & WB_REQ.stb & ack_q;
    assign wr_fire = wb_fire & WB_REQ.we & WB_REQ.sel[0];
    assign rd_fire = wb_fire & ~WB_REQ.we;
    assign WB_ACK_O = ack_q;

    // ack generation
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= WB_REQ.cyc & WB_REQ.stb & ~ack_q;
        end
    end

    // mode control register, bit 0 kept at zero
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q <= ccs_pkg::RST_MODE_CTRL;
        end else if (wr_fire && WB_REQ.adr == ccs_pkg::OFS_MODE_CTRL) begin
            ctrl_q <= {WB_REQ.dat[7:1], 1'b0};
        end
    end

    // control outputs to engine and buffer window
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            MODE_REQ   <= ccs_pkg::MODE_CONFIG;
            ABORT_ALL  <= 1'b0;
            WIN_BUF_EN <= 5'h01;
        end else begin
            MODE_REQ   <= mode_decode(ctrl_q[ccs_pkg::REQ_MSB:ccs_pkg::REQ_LSB]);
            ABORT_ALL  <= ctrl_q[ccs_pkg::ABORT_BIT];
            WIN_BUF_EN <= win_decode(ctrl_q[ccs_pkg::WIN_MSB:ccs_pkg::WIN_LSB]);
        end
    end

    // mode in force tracks engine only on legal codes
    assign mode_ok = ENGINE_MODE <= ccs_pkg::MODE_CONFIG;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_q <= ccs_pkg::RST_MODE;
        end else if (mode_ok) begin
            mode_q <= ENGINE_MODE;
        end
    end

    // prioritised interrupt source code, highest code first
    always_comb begin
        if (IRQ_SRC.wake) begin
            code_d = ccs_pkg::CODE_WAKE;
        end else if (IRQ_SRC.receive_buffer_zero) begin
            code_d = ccs_pkg::CODE_RECEIVE_BUFFER_ZERO;
        end else if (IRQ_SRC.receive_buffer_one) begin
            code_d = ccs_pkg::CODE_RECEIVE_BUFFER_ONE;
        end else if (IRQ_SRC.transmit_buffer_zero) begin
            code_d = ccs_pkg::CODE_TRANSMIT_BUFFER_ZERO;
        end else if (IRQ_SRC.transmit_buffer_one) begin
            code_d = ccs_pkg::CODE_TRANSMIT_BUFFER_ONE;
        end else if (IRQ_SRC.transmit_buffer_two) begin
            code_d = ccs_pkg::CODE_TRANSMIT_BUFFER_TWO;
        end else if (IRQ_SRC.error) begin
            code_d = ccs_pkg::CODE_ERROR;
        end else begin
            code_d = ccs_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            code_q <= ccs_pkg::CODE_NONE;
        end else begin
            code_q <= code_d;
        end
    end

    assign IRQ_CODE = code_q;

    // overflow flags: event sets, a written zero clears, set wins
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ovfl_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 && RX0_OVF_EV) || (i == 1 && RX1_OVF_EV)) begin
                    ovfl_q[i] <= 1'b1;
                end else if (wr_fire && WB_REQ.adr == ccs_pkg::OFS_ERR_STAT
                             && !WB_REQ.dat[7-i]) begin
                    ovfl_q[i] <= 1'b0;
                end
            end
        end
    end

    // error state flags from the counters, overflow flags from ovfl_q
    always_comb begin
        err_d            = '0;
        err_d.rx0_ovfl   = ovfl_q[0];
        err_d.rx1_ovfl   = ovfl_q[1];
        err_d.tx_busoff  = TX_ERR_CNT > CNT_W'(ccs_pkg::LIM_BUSOFF);
        err_d.tx_passive = TX_ERR_CNT > CNT_W'(ccs_pkg::LIM_PASSIVE);
        err_d.rx_passive = RX_ERR_CNT > CNT_W'(ccs_pkg::LIM_PASSIVE);
        err_d.tx_warn    = TX_ERR_CNT > CNT_W'(ccs_pkg::LIM_WARN)
                           && TX_ERR_CNT <= CNT_W'(ccs_pkg::LIM_PASSIVE);
        err_d.rx_warn    = RX_ERR_CNT > CNT_W'(ccs_pkg::LIM_WARN)
                           && RX_ERR_CNT <= CNT_W'(ccs_pkg::LIM_PASSIVE);
        err_d.any_warn   = err_d.tx_warn | err_d.rx_warn;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            err_q <= '0;
        end else begin
            err_q <= err_d;
        end
    end

    // events: overflows, bus-off, passive and warning entry, mode change
    assign irq_ev = {mode_ok && ENGINE_MODE != mode_q,
                     err_d.any_warn & ~err_q.any_warn,
                     (err_d.tx_passive | err_d.rx_passive)
                         & ~(err_q.tx_passive | err_q.rx_passive),
                     err_d.tx_busoff & ~err_q.tx_busoff,
                     RX1_OVF_EV,
                     RX0_OVF_EV};

    // sticky interrupt status, cleared by its read, set wins
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_q <= 6'h00;
        end else if (rd_fire && WB_REQ.adr == ccs_pkg::OFS_IRQ_STAT) begin
            // only bits returned by this read clear, later arrivals survive
            irq_stat_q <= (irq_stat_q & ~WB_DAT_O[5:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    // interrupt mask register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_mask_q <= ccs_pkg::RST_IRQ_MASK;
        end else if (wr_fire && WB_REQ.adr == ccs_pkg::OFS_IRQ_MASK) begin
            irq_mask_q <= WB_REQ.dat[5:0];
        end
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

    // read data, registered with the ack; unmapped reads return zero
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (WB_REQ.cyc && WB_REQ.stb && !ack_q && !WB_REQ.we) begin
            unique case (WB_REQ.adr)
                ccs_pkg::OFS_MODE_CTRL: WB_DAT_O <= {24'h00_0000, ctrl_q};
                ccs_pkg::OFS_MODE_STAT:
                    WB_DAT_O <= {24'h00_0000, mode_q, 1'b0, code_q, 1'b0};
                ccs_pkg::OFS_ERR_STAT:  WB_DAT_O <= {24'h00_0000, err_q};
                ccs_pkg::OFS_IRQ_STAT:  WB_DAT_O <= {26'h000_0000, irq_stat_q};
                ccs_pkg::OFS_IRQ_MASK:  WB_DAT_O <= {26'h000_0000, irq_mask_q};
                default:                WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    chk_req_config: assert property (@(posedge CLK) disable iff (!RESET_N)
        ctrl_q[ccs_pkg::REQ_MSB] |=> MODE_REQ == ccs_pkg::MODE_CONFIG)
        else $error("config request not decoded");

    chk_abort_follow: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(ctrl_q[ccs_pkg::ABORT_BIT]) |=> ABORT_ALL ##1 (ABORT_ALL || !$past(ctrl_q[4])))
        else $error("abort-all not driven");

    chk_window_rx0: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ctrl_q[3:1] inside {3'h0, 3'h1, 3'h6, 3'h7}) |=> WIN_BUF_EN == 5'h01)
        else $error("window default not receive buffer 0");

    chk_window_code: assert property (@(posedge CLK) disable iff (!RESET_N)
        IRQ_SRC == 7'h08 ##1 ctrl_q[3:1] == code_q |=> WIN_BUF_EN == 5'h04)
        else $error("copied code selects wrong buffer");

    chk_mode_legal: assert property (@(posedge CLK) disable iff (!RESET_N)
        mode_q <= ccs_pkg::MODE_CONFIG)
        else $error("reserved mode reported");

    chk_mode_engine: assert property (@(posedge CLK) disable iff (!RESET_N)
        !$stable(mode_q) |-> mode_q == $past(ENGINE_MODE))
        else $error("mode changed without engine");

    chk_code_wake: assert property (@(posedge CLK) disable iff (!RESET_N)
        IRQ_SRC.wake |=> IRQ_CODE == ccs_pkg::CODE_WAKE)
        else $error("wake not top priority");

    chk_code_none: assert property (@(posedge CLK) disable iff (!RESET_N)
        IRQ_SRC == '0 |=> IRQ_CODE == ccs_pkg::CODE_NONE)
        else $error("code without source");

    chk_ovfl_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
        (RX0_OVF_EV || (ovfl_q[0] && !(wr_fire && WB_REQ.adr == ccs_pkg::OFS_ERR_STAT
            && !WB_REQ.dat[7]))) |=> ovfl_q[0])
        else $error("overflow flag lost");

    chk_ovfl_one: assert property (@(posedge CLK) disable iff (!RESET_N)
        RX1_OVF_EV |=> ovfl_q[1] ##1 err_q.rx1_ovfl)
        else $error("overflow 1 flag not set");

    chk_busoff_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
        TX_ERR_CNT > 9'd255 |=> err_q.tx_busoff)
        else $error("bus-off flag missing");

    chk_warn_band: assert property (@(posedge CLK) disable iff (!RESET_N)
        TX_ERR_CNT == 9'd96 |=> err_q.tx_warn && err_q.any_warn && !err_q.tx_passive)
        else $error("warning band wrong");

    chk_rx_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
        RX_ERR_CNT == 9'd128 |=> err_q.rx_passive && !err_q.rx_warn)
        else $error("receive passive wrong");

    chk_irq_level: assert property (@(posedge CLK) disable iff (!RESET_N)
        RX0_OVF_EV && irq_mask_q[0] |=> IRQ)
        else $error("masked-in event gave no interrupt");

    chk_abort_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
        !ctrl_q[ccs_pkg::ABORT_BIT] |=> !ABORT_ALL)
        else $error("abort-all driven while bit clear");

    chk_ctrl_bit0: assert property (@(posedge CLK) disable iff (!RESET_N)
        ctrl_q[0] == 1'b0)
        else $error("control bit 0 not zero");

    chk_passive_tx: assert property (@(posedge CLK) disable iff (!RESET_N)
        TX_ERR_CNT == 9'd128 |=> err_q.tx_passive && !err_q.tx_warn)
        else $error("transmit passive wrong");

    chk_warn_rx: assert property (@(posedge CLK) disable iff (!RESET_N)
        RX_ERR_CNT == 9'd96 |=> err_q.rx_warn && err_q.any_warn && !err_q.rx_passive)
        else $error("receive warning band wrong");

    chk_warn_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
        TX_ERR_CNT <= 9'd95 && RX_ERR_CNT <= 9'd95 |=> !err_q.any_warn)
        else $error("warning without counter");

    chk_code_rx0: assert property (@(posedge CLK) disable iff (!RESET_N)
        !IRQ_SRC.wake && IRQ_SRC.receive_buffer_zero |=> IRQ_CODE == ccs_pkg::CODE_RECEIVE_BUFFER_ZERO)
        else $error("receive buffer 0 priority wrong");

    chk_ack_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");

    chk_event_kept: assert property (@(posedge CLK) disable iff (!RESET_N)
        irq_ev != 6'h00 |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
        else $error("interrupt event lost");

    chk_mode_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        !mode_ok |=> $stable(mode_q))
        else $error("mode moved on reserved engine code");

endmodule : ccs_control_status

// *** test/ccs_engine_model.sv ***
// behavioural protocol engine that enters a requested mode after a delay
`timescale 1ns/1ps
module ccs_engine_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // mode handshake, delay of at least one cycle
    input  wire logic [2:0] mode_req,
    input  wire logic [3:0] delay,
    input  wire logic       junk,
    output logic [2:0]      engine_mode
);
    logic [3:0] cnt_q;
    logic [2:0] mode_q;

    // mode follows the request late, junk shows a reserved code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= 4'h0;
            mode_q <= 3'h4;
        end else if (junk) begin
            mode_q <= 3'h7;
        end else if (cnt_q == 4'h1) begin
            mode_q <= mode_req;
            cnt_q  <= 4'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (mode_q != mode_req) begin
            cnt_q <= delay;
        end
    end
    assign engine_mode = mode_q;
endmodule : ccs_engine_model

// *** test/ccs_control_status_bench.sv ***
// self-checking bench for the can control and status block
`timescale 1ns/1ps
module ccs_control_status_bench;
    logic                  clk;
    logic                  reset_n;
    ccs_pkg::ccs_wb_req_t  wb_req;
    logic [31:0]           wb_dat;
    logic                  wb_ack;
    logic [2:0]            mode_req;
    logic [2:0]            eng_mode;
    logic                  abort_all;
    logic [4:0]            win_en;
    ccs_pkg::ccs_irq_src_t irq_src;
    logic [2:0]            irq_code;
    logic [8:0]            tx_cnt;
    logic [8:0]            rx_cnt;
    logic                  ovf0;
    logic                  ovf1;
    logic                  irq;
    logic [3:0]            dly;
    logic                  junk;
    int                    mismatches;
    int                    cmp_count;
    logic [31:0]           seed;
    logic [31:0]           v;
    logic [7:0]            rd;
    logic [2:0]            cur;
    logic [8:0]            corner [8];

    ccs_control_status ccs_control_status_inst (
        .CLK(clk), .RESET_N(reset_n), .WB_REQ(wb_req), .WB_DAT_O(wb_dat),
        .WB_ACK_O(wb_ack), .MODE_REQ(mode_req), .ENGINE_MODE(eng_mode),
        .ABORT_ALL(abort_all), .WIN_BUF_EN(win_en), .IRQ_SRC(irq_src),
        .IRQ_CODE(irq_code), .TX_ERR_CNT(tx_cnt), .RX_ERR_CNT(rx_cnt),
        .RX0_OVF_EV(ovf0), .RX1_OVF_EV(ovf1), .IRQ(irq));
    ccs_engine_model ccs_engine_model_inst (
        .clk(clk), .reset_n(reset_n), .mode_req(mode_req), .delay(dly),
        .junk(junk), .engine_mode(eng_mode));

    // xorshift source and expectations
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [2:0] exp_req(logic [2:0] r);
        return r[2] ? 3'h4 : r;
    endfunction : exp_req
    function automatic logic [4:0] exp_win(logic [2:0] w);
        case (w)
            3'h5: return 5'h02;
            3'h4: return 5'h04;
            3'h3: return 5'h08;
            3'h2: return 5'h10;
            default: return 5'h01;
        endcase
    endfunction : exp_win
    function automatic logic [2:0] exp_code(logic [6:0] s);
        for (int i = 6; i >= 0; i--) if (s[i]) return 3'(i + 1);
        return 3'h0;
    endfunction : exp_code
    function automatic logic [7:0] exp_err(logic [8:0] t, logic [8:0] r);
        logic tw;
        logic rw;
        tw = t > 95 && t <= 127;
        rw = r > 95 && r <= 127;
        return {2'b00, t > 255, t > 127, r > 127, tw, rw, tw | rw};
    endfunction : exp_err

    // classic wishbone cycle, held until ack is sampled
    task automatic wb(logic we, logic [7:0] a, logic [7:0] d);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: {24'h000000, d}};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat[7:0];
        wb_req <= '0;
        if (n >= 50) mismatches++;
        @(posedge clk);
    endtask : wb
    task automatic wr(logic [7:0] a, logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdr(logic [7:0] a);
        wb(1'b0, a, 8'h00);
    endtask : rdr
    task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg
    task automatic chk_pin(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    // main sequence
    initial begin
        reset_n = 1'b0; wb_req = '0; irq_src = '0; tx_cnt = 9'h000; rx_cnt = 9'h000;
        ovf0 = 1'b0; ovf1 = 1'b0; dly = 4'h6; junk = 1'b0; mismatches = 0; cmp_count = 0;
        seed = 32'd87623; cur = 3'h4;
        corner = '{9'h000, 9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h1ff};
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdr(ccs_pkg::OFS_MODE_CTRL);
        chk_reg("ctrl", ccs_pkg::RST_MODE_CTRL, rd);
        rdr(ccs_pkg::OFS_MODE_STAT);
        chk_reg("stat", 8'h80, rd);
        chk_pin("win", 8'h01, 8'(win_en));
        chk_pin("abort", 8'h00, 8'(abort_all));
        $display("test reset done");
        // each request code 0 to 7 is requested in turn and left to settle before the next step
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            dly <= 4'(6 + v % 8);
            wr(ccs_pkg::OFS_MODE_CTRL, {3'(i), 5'h00});
            @(posedge clk);
            chk_pin("mode_req", 8'(exp_req(3'(i))), 8'(mode_req));
            rdr(ccs_pkg::OFS_MODE_STAT);
            chk_reg("stat_old", {cur, 5'h00}, rd);
            repeat (20) @(posedge clk);
            cur = exp_req(3'(i));
            rdr(ccs_pkg::OFS_MODE_STAT);
            chk_reg("stat_new", {cur, 5'h00}, rd);
        end
        junk <= 1'b1;
        @(posedge clk);
        junk <= 1'b0;
        repeat (2) @(posedge clk);
        rdr(ccs_pkg::OFS_MODE_STAT);
        chk_reg("stat_rsvd", {cur, 5'h00}, rd);
        repeat (20) @(posedge clk);
        $display("test mode done");
        for (int w = 0; w < 8; w++) begin
            v = rnd();
            wr(ccs_pkg::OFS_MODE_CTRL, {cur, v[0], 3'(w), 1'b1});
            @(posedge clk);
            chk_pin("win", 8'(exp_win(3'(w))), 8'(win_en));
            chk_pin("abort", 8'(v[0]), 8'(abort_all));
            rdr(ccs_pkg::OFS_MODE_CTRL);
            chk_reg("ctrl", {cur, v[0], 3'(w), 1'b0}, rd);
        end
        $display("test window done");
        for (int k = 0; k < 24; k++) begin
            v = rnd();
            irq_src <= ccs_pkg::ccs_irq_src_t'(k < 7 ? 7'(1 << k) : (k == 7 ? 7'h7f : v[6:0]));
            repeat (2) @(posedge clk);
            chk_pin("code", 8'(exp_code(7'(irq_src))), 8'(irq_code));
            rdr(ccs_pkg::OFS_MODE_STAT);
            chk_reg("stat_code", {cur, 1'b0, exp_code(7'(irq_src)), 1'b0}, rd);
            if (k >= 1 && k <= 5) begin
                wr(ccs_pkg::OFS_MODE_CTRL, {cur, 1'b0, rd[3:1], 1'b0});
                @(posedge clk);
                chk_pin("win_copy", 8'(5'h01 << (5 - k)), 8'(win_en));
            end
        end
        irq_src <= '0;
        $display("test code done");
        for (int k = 0; k < 16; k++) begin
            v = rnd();
            tx_cnt <= (k < 8) ? corner[k] : v[8:0];
            rx_cnt <= (k < 8) ? corner[7 - k] : v[24:16];
            repeat (3) @(posedge clk);
            rdr(ccs_pkg::OFS_ERR_STAT);
            chk_reg("err", exp_err(tx_cnt, rx_cnt), rd & 8'h3f);
        end
        $display("test counters done");
        rdr(ccs_pkg::OFS_IRQ_STAT);
        chk_reg("irq_events", 8'h3c, rd);
        wr(ccs_pkg::OFS_IRQ_MASK, 8'h01);
        ovf0 <= 1'b1;
        @(posedge clk);
        ovf0 <= 1'b0;
        repeat (2) @(posedge clk);
        chk_pin("irq", 8'h01, 8'(irq));
        rdr(ccs_pkg::OFS_ERR_STAT);
        rdr(ccs_pkg::OFS_ERR_STAT);
        chk_reg("ovfl", 8'h80, rd & 8'hc0);
        rdr(ccs_pkg::OFS_IRQ_STAT);
        chk_reg("irq_stat", 8'h01, rd & 8'h01);
        chk_pin("irq_clr", 8'h00, 8'(irq));
        wr(ccs_pkg::OFS_IRQ_MASK, 8'h00);
        ovf1 <= 1'b1;
        @(posedge clk);
        ovf1 <= 1'b0;
        repeat (2) @(posedge clk);
        chk_pin("irq_mask", 8'h00, 8'(irq));
        wr(ccs_pkg::OFS_IRQ_MASK, 8'h02);
        chk_pin("irq_late", 8'h01, 8'(irq));
        wr(ccs_pkg::OFS_ERR_STAT, 8'hc0);
        rdr(ccs_pkg::OFS_ERR_STAT);
        chk_reg("ovfl", 8'hc0, rd & 8'hc0);
        wr(ccs_pkg::OFS_ERR_STAT, 8'h40);
        rdr(ccs_pkg::OFS_ERR_STAT);
        chk_reg("ovfl", 8'h40, rd & 8'hc0);
        wr(ccs_pkg::OFS_ERR_STAT, 8'h00);
        rdr(ccs_pkg::OFS_ERR_STAT);
        chk_reg("ovfl", 8'h00, rd & 8'hc0);
        $display("test overflow done");
        rdr(8'h20);
        chk_reg("unmapped", 8'h00, rd);
        wr(ccs_pkg::OFS_MODE_STAT, 8'hff);
        rdr(ccs_pkg::OFS_MODE_STAT);
        chk_reg("stat_ro", {cur, 5'h00}, rd);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk_pin("mode_req", 8'h04, 8'(mode_req));
        rdr(ccs_pkg::OFS_MODE_CTRL);
        chk_reg("ctrl", ccs_pkg::RST_MODE_CTRL, rd);
        $display("test rereset done");
        print_verdict();
    end
endmodule : ccs_control_status_bench
